// file: rtl/enc_guest_exit.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// encrypted guest world switch and exit control
// ------------------------------------------------------------------
module enc_guest_exit (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // world entry request and its control block fields
   input wire logic i_entry_req,
   input wire logic i_enc_mode,
   input wire logic [10:0] i_clean_bits,
   input wire logic [63:0] i_save_ptr,
   input wire logic [63:0] i_vm_control_block_comm_page,
   input wire logic i_inject_valid,
   input wire logic i_inject_soft,
   input wire logic [7:0] i_inject_vec,
   // memory step engine answers
   input wire logic i_step_done,
   input wire logic i_step_fault,
   input wire logic i_csum_ok,
   // guest events
   input wire logic i_evt_valid,
   input wire logic [11:0] i_evt_code,
   input wire logic i_evt_intercept,
   input wire logic i_pf_rsvd,
   input wire logic [63:0] i_trap_value,
   input wire logic [63:0] i_ip_next,
   // instruction bytes for decode
   input wire logic [7:0] i_insn_pfx,
   input wire logic [7:0] i_insn_b0,
   input wire logic [7:0] i_insn_b1,
   input wire logic [7:0] i_insn_b2,
   input wire logic i_insn_valid,
   // register access
   input wire logic i_msr_wr,
   input wire logic i_msr_rd,
   input wire logic [31:0] i_msr_addr,
   input wire logic [63:0] i_msr_wdata,
   input wire logic i_feat_wr,
   input wire logic [63:0] i_feat_wdata,
   // outputs
   output logic o_running,
   output logic [2:0] o_mem_step,
   output logic o_mem_is_guest,
   output logic o_mem_encrypted,
   output logic [63:0] o_mem_base,
   output logic o_full_reload,
   output logic o_exit_valid,
   output logic [11:0] o_exit_code,
   output logic [63:0] o_exit_info1,
   output logic [63:0] o_saved_ip,
   output logic [63:0] o_vm_control_block_comm_page,
   output logic o_insn_bytes_wr,
   output logic o_exc_valid,
   output logic [7:0] o_exc_vec,
   output logic [31:0] o_exc_err,
   output logic o_is_hypercall,
   output logic o_gp_fault,
   output logic [63:0] o_msr_rdata,
   output logic [63:0] o_feat_q
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      egx_pkg::step_t step;   // world switch sequence
      logic enc;              // current guest is encrypted
      logic [63:0] save_ptr;  // save area page
      logic [63:0] comm_page; // comm page address register
      logic [63:0] feat;      // extended feature register
      logic exit_v;           // one-cycle exit pulse
      logic [11:0] code;      // latched exit code
      logic [63:0] info1;     // exit info field
      logic [63:0] sip;       // saved instruction pointer
      logic exc_v;            // one-cycle exception pulse
      logic [31:0] exc_err;   // exception error code
      logic gp;               // one-cycle fault pulse
      logic [63:0] rdata;     // register read data
      logic hcall;            // hypercall decoded
   } state_t;

   state_t s_q;
   state_t s_d;
   logic cls_auto;
   logic cls_adv;
   logic req_instr;
   logic bad_inject;
   logic guest;

   // classifier leaf
   exit_classifier u_cls (
      .i_code(i_evt_code),
      .i_pf_rsvd(i_pf_rsvd),
      .o_auto(cls_auto),
      .o_adv_ip(cls_adv)
   );

   // prefix plus hypercall opcode
   function automatic logic is_req(input logic [7:0] p,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      is_req = (p == egx_pkg::PFX_REP || p == egx_pkg::PFX_REPNE) &&
               a == egx_pkg::OP_ESC && b == egx_pkg::OP_GRP &&
               c == egx_pkg::OP_CALL;
   endfunction

   function automatic logic is_call(input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] c);
      is_call = a == egx_pkg::OP_ESC && b == egx_pkg::OP_GRP &&
                c == egx_pkg::OP_CALL;
   endfunction

   assign guest = (s_q.step == egx_pkg::ST_RUN);
   assign req_instr = i_insn_valid && s_q.enc &&
      is_req(i_insn_pfx, i_insn_b0, i_insn_b1, i_insn_b2);
   // soft interrupts and vectors 3 and 4 are refused on encrypted entries only
   assign bad_inject = i_enc_mode && i_inject_valid &&
      (i_inject_soft || i_inject_vec == egx_pkg::VEC_BP ||
       i_inject_vec == egx_pkg::VEC_OF);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.exit_v = 1'b0;
      s_d.exc_v = 1'b0;
      s_d.gp = 1'b0;
      s_d.hcall = 1'b0;
      // register port; hypervisor access faults
      if ((i_msr_wr || i_msr_rd) &&
          i_msr_addr == egx_pkg::MSR_COMM_PAGE)
      begin
         if (!guest)
            s_d.gp = 1'b1;
         else if (i_msr_wr)
            s_d.comm_page = i_msr_wdata;
         else
            s_d.rdata = s_q.comm_page;
      end
      // feature writes: virt enable bit kept in encrypted guest
      if (i_feat_wr)
      begin
         s_d.feat = i_feat_wdata;
         if (guest && s_q.enc)
            s_d.feat[egx_pkg::FEAT_VIRT_BIT] =
               s_q.feat[egx_pkg::FEAT_VIRT_BIT];
      end
      case (s_q.step)
         egx_pkg::ST_IDLE:
         begin
            if (i_entry_req)
            begin
               s_d.enc = i_enc_mode;
               s_d.save_ptr = i_save_ptr;
               s_d.comm_page = i_vm_control_block_comm_page;
               if (bad_inject)
                  s_d.step = egx_pkg::ST_FAIL;
               else if (i_enc_mode)
                  s_d.step = egx_pkg::ST_E_CSUM;
               else
                  s_d.step = egx_pkg::ST_RUN;
            end
         end
         egx_pkg::ST_E_CSUM:
         begin
            if (i_step_fault || (i_step_done && !i_csum_ok))
               s_d.step = egx_pkg::ST_FAIL;
            else if (i_step_done)
               s_d.step = egx_pkg::ST_E_EXTRA;
         end
         egx_pkg::ST_E_EXTRA:
         begin
            if (i_step_fault)
               s_d.step = egx_pkg::ST_FAIL;
            else if (i_step_done)
               s_d.step = egx_pkg::ST_E_GPR;
         end
         egx_pkg::ST_E_GPR:
         begin
            if (i_step_fault)
               s_d.step = egx_pkg::ST_FAIL;
            else if (i_step_done)
               s_d.step = egx_pkg::ST_E_FPU;
         end
         egx_pkg::ST_E_FPU:
         begin
            if (i_step_fault)
               s_d.step = egx_pkg::ST_FAIL;
            else if (i_step_done)
               s_d.step = egx_pkg::ST_RUN;
         end
         egx_pkg::ST_RUN:
         begin
            // request instruction exits with no intercept gate
            if (req_instr)
            begin
               s_d.code = egx_pkg::EXIT_GUEST_REQ;
               s_d.sip = i_ip_next;
               s_d.info1 = '0;
               s_d.step = egx_pkg::ST_X_EXTRA;
            end
            else if (i_evt_valid && i_evt_intercept)
            begin
               // one outcome only: exit or exception
               if (!s_q.enc || cls_auto)
               begin
                  s_d.code = i_evt_code;
                  s_d.info1 = i_trap_value;
                  if (cls_adv && s_q.enc)
                     s_d.sip = i_ip_next;
                  s_d.step = s_q.enc ? egx_pkg::ST_X_EXTRA
                                     : egx_pkg::ST_X_HGPR;
               end
               else
               begin
                  s_d.exc_v = 1'b1;
                  s_d.exc_err = {20'h0, i_evt_code};
               end
            end
            else if (i_insn_valid && !s_q.enc &&
                     is_call(i_insn_b0, i_insn_b1, i_insn_b2))
               s_d.hcall = 1'b1;
         end
         egx_pkg::ST_X_EXTRA:
            if (i_step_done)
               s_d.step = egx_pkg::ST_X_GPR;
         egx_pkg::ST_X_GPR:
            if (i_step_done)
               s_d.step = egx_pkg::ST_X_FPU;
         egx_pkg::ST_X_FPU:
            if (i_step_done)
               s_d.step = egx_pkg::ST_X_CSUM;
         egx_pkg::ST_X_CSUM:
            if (i_step_done)
               s_d.step = egx_pkg::ST_X_HEXTRA;
         egx_pkg::ST_X_HEXTRA:
            if (i_step_done)
               s_d.step = egx_pkg::ST_X_HGPR;
         egx_pkg::ST_X_HGPR:
            if (i_step_done)
               s_d.step = s_q.enc ? egx_pkg::ST_X_FPURST
                                  : egx_pkg::ST_IDLE;
         egx_pkg::ST_X_FPURST:
         begin
            if (i_step_done)
            begin
               s_d.exit_v = 1'b1;
               s_d.step = egx_pkg::ST_IDLE;
            end
         end
         egx_pkg::ST_FAIL:
         begin
            s_d.code = egx_pkg::EXIT_INVALID;
            s_d.exit_v = 1'b1;
            s_d.step = egx_pkg::ST_IDLE;
         end
         default:
            s_d.step = egx_pkg::ST_IDLE;
      endcase
      // plain guests finish on host load
      if (s_q.step == egx_pkg::ST_X_HGPR && i_step_done && !s_q.enc)
         s_d.exit_v = 1'b1;
   end

   // ---------------------------------------------------------------
   // register the state
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         s_q <= '0;
         s_q.step <= egx_pkg::ST_IDLE;
      end
      else
         s_q <= s_d;
   end

   // ---------------------------------------------------------------
   // memory step selector
   // ---------------------------------------------------------------
   always_comb
   begin
      case (s_q.step)
         egx_pkg::ST_E_CSUM: o_mem_step = egx_pkg::MS_CSUM_CHK;
         egx_pkg::ST_E_EXTRA: o_mem_step = egx_pkg::MS_EXTRA;
         egx_pkg::ST_E_GPR: o_mem_step = egx_pkg::MS_GPR;
         egx_pkg::ST_E_FPU: o_mem_step = egx_pkg::MS_FPU;
         egx_pkg::ST_X_EXTRA: o_mem_step = egx_pkg::MS_EXTRA;
         egx_pkg::ST_X_GPR: o_mem_step = egx_pkg::MS_GPR;
         egx_pkg::ST_X_FPU: o_mem_step = egx_pkg::MS_FPU;
         egx_pkg::ST_X_CSUM: o_mem_step = egx_pkg::MS_CSUM_ST;
         egx_pkg::ST_X_HEXTRA: o_mem_step = egx_pkg::MS_EXTRA;
         egx_pkg::ST_X_HGPR: o_mem_step = egx_pkg::MS_HOST;
         egx_pkg::ST_X_FPURST: o_mem_step = egx_pkg::MS_FPURST;
         default: o_mem_step = egx_pkg::MS_NONE;
      endcase
   end

   // guest-side steps touch the encrypted save page
   assign o_mem_is_guest = o_mem_step != egx_pkg::MS_NONE &&
      s_q.step != egx_pkg::ST_X_HEXTRA &&
      s_q.step != egx_pkg::ST_X_HGPR &&
      s_q.step != egx_pkg::ST_X_FPURST;
   assign o_mem_encrypted = o_mem_is_guest && s_q.enc;
   // host state is only the minimal legacy set; rest is software's
   assign o_mem_base = s_q.save_ptr;
   // encrypted guests drop every clean bit; plain guests honour them
   assign o_full_reload = s_q.enc || i_clean_bits == 11'h000;
   assign o_running = guest;
   assign o_exit_valid = s_q.exit_v;
   assign o_exit_code = s_q.code;
   assign o_exit_info1 = s_q.info1;
   assign o_saved_ip = s_q.sip;
   assign o_vm_control_block_comm_page = s_q.comm_page;
   assign o_insn_bytes_wr = 1'b0;
   assign o_exc_valid = s_q.exc_v;
   assign o_exc_vec = egx_pkg::VEC_COMM;
   assign o_exc_err = s_q.exc_err;
   assign o_is_hypercall = s_q.hcall;
   assign o_gp_fault = s_q.gp;
   assign o_msr_rdata = s_q.rdata;
   assign o_feat_q = s_q.feat;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_req_exit_code: assert property (@(posedge i_ref_clk)
      disable iff (!i_nrst) guest && req_instr |=>
      o_exit_code == egx_pkg::EXIT_GUEST_REQ)
      else $error("request instruction did not set exit code");
   a_exc_err: assert property (@(posedge i_ref_clk)
      disable iff (!i_nrst) o_exc_valid |->
      o_exc_err[11:0] == $past(i_evt_code))
      else $error("exception error code mismatch");
   a_npf_rsvd: assert property (@(posedge i_ref_clk)
      disable iff (!i_nrst) guest && s_q.enc && !req_instr &&
      i_evt_valid && i_evt_intercept &&
      i_evt_code == egx_pkg::EXIT_NPF && i_pf_rsvd |=> o_exc_valid)
      else $error("reserved nested fault not guest handled");
   a_one_outcome: assert property (@(posedge i_ref_clk)
      disable iff (!i_nrst) o_exc_valid |-> o_running && !o_exit_valid)
      else $error("exception outside guest run");
   a_gp_host: assert property (@(posedge i_ref_clk)
      disable iff (!i_nrst) !guest && i_msr_wr &&
      i_msr_addr == egx_pkg::MSR_COMM_PAGE |=> o_gp_fault &&
      o_vm_control_block_comm_page == $past(o_vm_control_block_comm_page))
      else $error("host access to comm page not faulted");
   a_bad_inject: assert property (@(posedge i_ref_clk)
      disable iff (!i_nrst) s_q.step == egx_pkg::ST_IDLE &&
      i_entry_req && bad_inject |=> ##1 o_exit_valid &&
      o_exit_code == egx_pkg::EXIT_INVALID)
      else $error("bad injection not refused");
   a_csum_fail: assert property (@(posedge i_ref_clk)
      disable iff (!i_nrst) s_q.step == egx_pkg::ST_E_CSUM &&
      i_step_done && !i_csum_ok |=> ##1 o_exit_valid)
      else $error("checksum failure not reported");
   a_virt_keep: assert property (@(posedge i_ref_clk)
      disable iff (!i_nrst) guest && s_q.enc && i_feat_wr |=>
      $stable(o_feat_q[egx_pkg::FEAT_VIRT_BIT]))
      else $error("virt enable bit changed by guest");
   a_entry_order: assert property (@(posedge i_ref_clk)
      disable iff (!i_nrst) s_q.step == egx_pkg::ST_E_CSUM &&
      i_step_done && i_csum_ok && !i_step_fault |=>
      o_mem_step == egx_pkg::MS_EXTRA)
      else $error("entry order broken");
   c_req_exit: cover property (@(posedge i_ref_clk)
      disable iff (!i_nrst) guest && req_instr);
   c_exc: cover property (@(posedge i_ref_clk)
      disable iff (!i_nrst) o_exc_valid);
   c_invalid: cover property (@(posedge i_ref_clk)
      disable iff (!i_nrst) o_exit_valid &&
      o_exit_code == egx_pkg::EXIT_INVALID);
endmodule
`default_nettype wire

// file: rtl/egx_pkg.sv
// How it works
// - instruction exits advance saved instruction pointer
// - nested fault automatic only without reserved error
// - never store instruction bytes on nested fault
// - guest-handled exit raises exception vector 29
// - exception error code equals exit code
// - decode hypercall opcode with repeat prefix
// - request instruction always exits, trap style
// - outside encrypted mode request acts as hypercall
// - comm page register saved/restored at 0a0h
// - comm page register access faults in hypervisor
// - save area via pointer at 108h
// - save area accesses use guest key
// - entry: checksum, extra, gprs, fpu order
// - entry fault or bad checksum gives invalid exit
// - ignore clean bits, reload everything
// - entry saves only minimal host state
// - reject soft interrupt, vectors 3 and 4
// - exit: save, checksum, load host, reset fpu
// - write traps exit after update, value in info
// - guest writes to virt enable ignored
// - only listed codes are automatic exits
// - events taken only when intercept set
package egx_pkg;
   // --------------------------------------------------------------
   // exit codes
   // --------------------------------------------------------------
   localparam logic [11:0] EXIT_MC = 12'h052;
   localparam logic [11:0] EXIT_INTR = 12'h060;
   localparam logic [11:0] EXIT_NMI = 12'h061;
   localparam logic [11:0] EXIT_INIT = 12'h063;
   localparam logic [11:0] EXIT_VINTR = 12'h064;
   localparam logic [11:0] EXIT_PAUSE = 12'h077;
   localparam logic [11:0] EXIT_HLT = 12'h078;
   localparam logic [11:0] EXIT_SHUTDOWN = 12'h07f;
   localparam logic [11:0] EXIT_FEAT_TRAP = 12'h08f;
   localparam logic [11:0] EXIT_CR_TRAP_LO = 12'h090;
   localparam logic [11:0] EXIT_CR_TRAP_HI = 12'h09f;
   localparam logic [11:0] EXIT_NPF = 12'h400;
   localparam logic [11:0] EXIT_GUEST_REQ = 12'h403;
   localparam logic [11:0] EXIT_INVALID = 12'hfff;
   // --------------------------------------------------------------
   // vectors, opcodes, offsets
   // --------------------------------------------------------------
   localparam logic [7:0] VEC_COMM = 8'h1d;
   localparam logic [7:0] VEC_BP = 8'h03;
   localparam logic [7:0] VEC_OF = 8'h04;
   localparam logic [7:0] OP_ESC = 8'h0f;
   localparam logic [7:0] OP_GRP = 8'h01;
   localparam logic [7:0] OP_CALL = 8'hd9;
   localparam logic [7:0] PFX_REP = 8'hf3;
   localparam logic [7:0] PFX_REPNE = 8'hf2;
   localparam logic [31:0] MSR_COMM_PAGE = 32'hc0010130;
   localparam logic [11:0] VM_CONTROL_BLOCK_COMM_PAGE = 12'h0a0;
   localparam logic [11:0] VM_CONTROL_BLOCK_SAVE_PTR = 12'h108;
   localparam logic [11:0] VM_CONTROL_BLOCK_LEGACY_SAVE = 12'h400;
   localparam logic [11:0] VM_CONTROL_BLOCK_INSN_BYTES = 12'h0d0;
   localparam int PF_RSVD_BIT = 3;
   localparam int FEAT_VIRT_BIT = 12;
   localparam logic [10:0] CLEAN_IGNORE_MASK = 11'h7e0;
   // --------------------------------------------------------------
   // world switch steps (gray along the usual path up to the return to ST_IDLE)
   // --------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_E_CSUM = 4'h1,
      ST_E_EXTRA = 4'h3,
      ST_E_GPR = 4'h2,
      ST_E_FPU = 4'h6,
      ST_RUN = 4'h7,
      ST_X_EXTRA = 4'h5,
      ST_X_GPR = 4'h4,
      ST_X_FPU = 4'hc,
      ST_X_CSUM = 4'hd,
      ST_X_HEXTRA = 4'hf,
      ST_X_HGPR = 4'he,
      ST_X_FPURST = 4'ha,
      ST_FAIL = 4'hb
   } step_t;
   // memory step selector driven to the save engine
   typedef enum logic [2:0] {
      MS_NONE = 3'h0,
      MS_CSUM_CHK = 3'h1,
      MS_EXTRA = 3'h2,
      MS_GPR = 3'h3,
      MS_FPU = 3'h4,
      MS_CSUM_ST = 3'h5,
      MS_HOST = 3'h6,
      MS_FPURST = 3'h7
   } mstep_t;
endpackage

// file: rtl/exit_classifier.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// exit classifier: automatic exit or guest-handled exit
// ------------------------------------------------------------------
module exit_classifier (
   input wire logic [11:0] i_code,
   input wire logic i_pf_rsvd,
   output logic o_auto,
   output logic o_adv_ip
);
   // only the fixed list reaches the hypervisor directly
   always_comb
   begin
      o_auto = 1'b0;
      o_adv_ip = 1'b0;
      case (i_code)
         egx_pkg::EXIT_MC, egx_pkg::EXIT_INTR, egx_pkg::EXIT_NMI,
         egx_pkg::EXIT_INIT, egx_pkg::EXIT_VINTR,
         egx_pkg::EXIT_SHUTDOWN:
            o_auto = 1'b1;
         egx_pkg::EXIT_PAUSE, egx_pkg::EXIT_HLT,
         egx_pkg::EXIT_FEAT_TRAP, egx_pkg::EXIT_GUEST_REQ:
         begin
            o_auto = 1'b1;
            o_adv_ip = 1'b1;
         end
         egx_pkg::EXIT_NPF:
            o_auto = !i_pf_rsvd;
         default:
         begin
            // write trap range rides along as instruction exits
            if (i_code >= egx_pkg::EXIT_CR_TRAP_LO &&
                i_code <= egx_pkg::EXIT_CR_TRAP_HI)
            begin
               o_auto = 1'b1;
               o_adv_ip = 1'b1;
            end
         end
      endcase
   end
endmodule
`default_nettype wire

// file: testbench/test_encrypted_guest_exit_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_encrypted_guest_exit_control;
   // ------------------------------------------------------------
   // stimulus, each given a value at time zero
   // ------------------------------------------------------------
   logic clk = 1'b0, nrst = 1'b0, enc = 1'b1, inj_v = 1'b0;
   logic inj_s = 1'b0, done = 1'b0, fault = 1'b0, csum = 1'b1;
   logic icpt = 1'b1, rsvd = 1'b0;
   logic [10:0] clean = 11'h7ff;
   logic [5:0] stb = 6'h00; // entry, event, instr, wr, rd, feature
   logic [7:0] ivec = 8'h00, pfx = 8'h00;
   logic [11:0] code = 12'h000;
   logic [31:0] maddr = 32'hc0010130;
   logic [63:0] vcp = 64'h1000, trapv = 64'h7777, ipn = 64'h4444;
   logic [63:0] mwd = 64'h0, fwd = 64'h0;
   // observed outputs
   logic run, menc, frel, xv, ibw, excv, hyp, gp, mig;
   logic [2:0] mstep;
   logic [7:0] evec;
   logic [11:0] xcode;
   logic [31:0] eerr;
   logic [63:0] mbase, info, sip, ocp, rdata, featq;
   wire [3:0] pul = {hyp, gp, excv, xv};
   int fails = 0, compares = 0, cyc = 0;
   // exit walk: guest extra, gpr, fpu, checksum, host extra, host, fpu
   localparam logic [2:0] xs [7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h2,
      3'h6, 3'h7};
   enc_guest_exit u_dut (
      .i_ref_clk(clk), .i_nrst(nrst), .i_entry_req(stb[0]),
      .i_enc_mode(enc), .i_clean_bits(clean), .i_save_ptr(64'h8000),
      .i_vm_control_block_comm_page(vcp), .i_inject_valid(inj_v),
      .i_inject_soft(inj_s), .i_inject_vec(ivec), .i_step_done(done),
      .i_step_fault(fault), .i_csum_ok(csum), .i_evt_valid(stb[1]),
      .i_evt_code(code), .i_evt_intercept(icpt), .i_pf_rsvd(rsvd),
      .i_trap_value(trapv), .i_ip_next(ipn), .i_insn_pfx(pfx),
      .i_insn_b0(8'h0f), .i_insn_b1(8'h01), .i_insn_b2(8'hd9),
      .i_insn_valid(stb[2]), .i_msr_wr(stb[3]), .i_msr_rd(stb[4]),
      .i_msr_addr(maddr), .i_msr_wdata(mwd), .i_feat_wr(stb[5]),
      .i_feat_wdata(fwd), .o_running(run), .o_mem_step(mstep),
      .o_mem_is_guest(mig), .o_mem_encrypted(menc), .o_mem_base(mbase),
      .o_full_reload(frel), .o_exit_valid(xv), .o_exit_code(xcode),
      .o_exit_info1(info), .o_saved_ip(sip), .o_vm_control_block_comm_page(ocp),
      .o_insn_bytes_wr(ibw), .o_exc_valid(excv), .o_exc_vec(evec),
      .o_exc_err(eerr), .o_is_hypercall(hyp), .o_gp_fault(gp),
      .o_msr_rdata(rdata), .o_feat_q(featq)
   );
   // clock and a ceiling on the run, so a hang still reports
   always #10 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         wrap_up;
      end
   end
   // inputs move 1 ns after the edge, away from sampling
   task automatic tk;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // bounded wait for one pulse: 0 exit, 1 exception, 2 gp, 3 call
   task automatic wait_p(input int k);
      int n;
      n = 0;
      while (pul[k] !== 1'b1 && n < 12)
      begin
         tk;
         n++;
      end
      chk(pul[k], 1'b1);
   endtask
   // one-cycle strobe, dropped after the edge that takes it
   task automatic pls(input int k);
      stb[k] = 1'b1;
      tk;
      stb[k] = 1'b0;
   endtask
   task automatic step(input logic [2:0] s);
      chk(mstep, s);
      done = 1'b1;
      tk;
      done = 1'b0;
   endtask
   task automatic go_run;
      pls(0);
      chk(menc, 1'b1);
      chk(mbase, 64'h8000);
      chk(frel, 1'b1);
      for (int k = 1; k < 5; k++)
         step(k[2:0]);
      tk;
      chk(run, 1'b1);
   endtask
   task automatic walk_exit(input logic [11:0] c);
      for (int k = 0; k < 7; k++)
      begin
         chk({mig, menc}, (k < 4) ? 2'b11 : 2'b00);
         step(xs[k]);
      end
      wait_p(0);
      chk(xcode, c);
   endtask
   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      #1;
      nrst = 1'b1;
      chk(evec, 8'h1d);
      mwd = 64'h5a;
      for (int k = 3; k < 5; k++)
      begin
         pls(k);
         wait_p(2);
      end
      $display("test host access done");
      // soft interrupt and vectors 3, 4 must fail the entry
      inj_v = 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         inj_s = (k == 2);
         ivec = (k == 0) ? 8'h03 : (k == 1) ? 8'h04 : 8'h20;
         pls(0);
         wait_p(0);
         chk(xcode, 12'hfff);
      end
      inj_v = 1'b0;
      // bad checksum, then a faulting step
      for (int k = 0; k < 2; k++)
      begin
         csum = k[0];
         fault = k[0];
         pls(0);
         step(3'h1);
         wait_p(0);
         chk(xcode, 12'hfff);
      end
      fault = 1'b0;
      $display("test failed entries done");
      go_run;
      pls(4);
      chk(rdata, 64'h1000);
      mwd = 64'h3000;
      pls(3);
      fwd = 64'h1001;
      pls(5);
      chk(featq, 64'h1);
      // not intercepted: nothing at all may happen
      icpt = 1'b0;
      code = 12'h07b;
      pls(1);
      repeat (3) tk;
      chk(pul, 4'h0);
      icpt = 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         rsvd = k[0];
         code = k ? 12'h400 : 12'h07b;
         pls(1);
         wait_p(1);
         chk(eerr, {20'h0, code});
         chk({run, xv}, 2'b10);
      end
      rsvd = 1'b0;
      $display("test guest-handled done");
      for (int k = 0; k < 2; k++)
      begin
         if (k == 1)
            go_run;
         pfx = k ? 8'hf3 : 8'hf2;
         pls(2);
         walk_exit(12'h403);
         chk(sip, 64'h4444);
         chk(ocp, k ? 64'h1000 : 64'h3000);
      end
      go_run;
      code = 12'h400;
      ipn = 64'h5555;
      pls(1);
      walk_exit(12'h400);
      chk(ibw, 1'b0);
      chk(sip, 64'h4444);
      go_run;
      code = 12'h09a;
      trapv = 64'h9999;
      pls(1);
      walk_exit(12'h09a);
      chk(info, 64'h9999);
      chk(sip, 64'h5555);
      $display("test automatic exits done");
      enc = 1'b0;
      pls(0);
      chk(frel, 1'b0);
      clean = 11'h000;
      tk;
      chk(frel, 1'b1);
      pfx = 8'hf3;
      pls(2);
      wait_p(3);
      $display("test plain guest done");
      wrap_up;
   end
endmodule
`default_nettype wire
